// ### include/cfrr_pkg.sv
// Package for the context fault result register slice
package cfrr_pkg;
	// Register byte offsets (chosen; no offsets printed)
	localparam logic [11:0] OFF_RESULT_LO = 12'h000;
	localparam logic [11:0] OFF_RESULT_HI = 12'h004;
	localparam logic [11:0] OFF_AUTH = 12'h008;
	localparam logic [11:0] OFF_CEID_LO = 12'h00C;
	localparam logic [11:0] OFF_CEID_HI = 12'h010;
	localparam logic [11:0] OFF_MON_CFG = 12'h014;
	localparam logic [11:0] OFF_CNT_CLR = 12'h018;
	localparam logic [11:0] OFF_CNT_SET = 12'h01C;
	localparam logic [11:0] OFF_CTX_CFG = 12'h020;
	// Fault layout bit positions
	localparam int POS_FAULT = 0;
	localparam int POS_NO_MAP = 1;
	localparam int POS_ACCESS = 2;
	localparam int POS_PERM = 3;
	localparam int POS_EXT = 4;
	localparam int POS_MATCH = 5;
	localparam int POS_LOCK = 6;
	localparam int POS_ADDR_SIZE = 7;
	localparam int POS_SCHEME = 8;
	localparam int POS_INV_CTX = 29;
	localparam int POS_OP_TERM = 31;
	localparam int POS_LEVEL = 32;
	localparam int POS_STAGE = 35;
	// Scheme codes
	localparam logic [1:0] SCHEME_SHORT = 2'h0;
	localparam logic [1:0] SCHEME_LONG = 2'h1;
	localparam logic [1:0] SCHEME_WIDE = 2'h2;
	// Monitor config fields
	localparam int POS_CFG_SIZE = 8;
	localparam logic [5:0] CFG_SIZE_REVEALED = 6'h1F;
	localparam logic [5:0] CFG_SIZE_NONE = 6'h00;
	// Context config register bits
	localparam int POS_CTX_WIDE = 0;
	localparam int POS_CTX_EXT = 1;
	localparam int POS_CTX_STAGE2 = 2;
	localparam logic [63:0] RESULT_RESET = 64'h0;
	localparam logic [31:0] SLVERR_DATA = 32'h0;

	typedef struct packed {
		logic paddr_unused;
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} cfrr_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cfrr_apb_rsp_t;

	// Abort report from the walker
	typedef struct packed {
		logic valid;
		logic stage2;
		logic [1:0] level;
		logic op_terminated;
		logic invalid_context;
		logic addr_size;
		logic cache_lock;
		logic match_conflict;
		logic external;
		logic permission;
		logic access_bit;
		logic no_mapping;
	} cfrr_fault_t;

	// Global counter group view
	typedef struct packed {
		logic revealed;
		logic [31:0] auth;
		logic [31:0] ceid_lo;
		logic [31:0] ceid_hi;
		logic [31:0] enables;
		logic [4:0] counter_count;
	} cfrr_group_t;
endpackage

// ### rtl/cfrr_regs.sv
// Per-context fault result and monitor mirror register slice
`timescale 1ns/10ps
// Operation
// - On abort, write fault layout and set bit 0.
// - Bit 35 reports faulting stage, 0 first, 1 second.
// - Bits 33:32 encode the faulting walk level 0..3.
// - Bit 31 set when the operation was terminated.
// - Bit 29 set when transaction mapped to Fault.
// - Bits 9:8 give scheme: short 0, long 1, wide 2.
// - Code 3 reserved; stage-2 never reports short code.
// - Scheme field read-only, from wide select, extended enable and stage-2 config.
// - Bit 7 set on incorrect address size fault.
// - Bit 6 set on cache lock fault, optionally read-as-zero.
// - Bit 5 set on match conflict, optionally read-as-zero.
// - Bit 4 set on external walk fault, optionally read-as-zero.
// - Bit 3 set on insufficient permission.
// - Bit 2 set on access flag fault.
// - Bit 1 set when no valid mapping exists.
// - Auth mirror uses global format when group revealed.
// - Two event id mirrors copy global when revealed.
// - Config reports counter count; group count reads unknown.
// - Config reads zero unrevealed; size 0x1F when revealed.
// - Enable-clear bit j clears counter j enable.
// - Enable-set bit j sets counter j enable.
module cfrr_regs
	import cfrr_pkg::*;
#(
	parameter bit HAS_LOCK = 1'b1,
	parameter bit HAS_MATCH = 1'b1,
	parameter bit HAS_EXT = 1'b1,
	parameter int NUM_COUNTERS = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire cfrr_pkg::cfrr_apb_req_t apb_req,
	output cfrr_pkg::cfrr_apb_rsp_t apb_rsp,
	input wire cfrr_pkg::cfrr_fault_t fault,
	input wire cfrr_pkg::cfrr_group_t group,
	output logic [31:0] enable_clear,
	output logic [31:0] enable_set,
	output logic wide_scheme_select,
	output logic extended_addr_enable
);
	import cfrr_pkg::*;

	// Counter mask cannot serve more than one word of counters
	if (NUM_COUNTERS < 1 || NUM_COUNTERS > 32) begin : g_bad_count
		$error("NUM_COUNTERS must be 1..32");
	end

	typedef struct packed {
		logic [63:0] result;
		logic wide;
		logic ext;
		logic stage2;
		logic [31:0] rdata;
		logic slverr;
		logic [31:0] clr;
		logic [31:0] set;
	} cfrr_state_t;

	cfrr_state_t s_q;
	cfrr_state_t s_d;
	logic acc;
	logic wr;
	logic [1:0] scheme;
	logic [63:0] fault_word;
	logic [31:0] cfg_word;
	logic [31:0] cnt_mask;

	default clocking cb_main @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Scheme code from configuration only
	function automatic logic [1:0] scheme_of(logic wide, logic ext,
			logic st2);
		if (wide) begin
			return SCHEME_WIDE;
		end else if (ext || st2) begin
			return SCHEME_LONG;
		end
		return SCHEME_SHORT;
	endfunction

	assign acc = apb_req.psel && apb_req.penable;
	assign wr = acc && apb_req.pwrite;
	assign scheme = scheme_of(s_q.wide, s_q.ext, s_q.stage2);
	assign cnt_mask = (NUM_COUNTERS == 32) ? 32'hFFFFFFFF :
		((32'h1 << NUM_COUNTERS) - 32'h1);

	always_comb begin
		fault_word = '0;
		fault_word[POS_FAULT] = 1'b1;
		fault_word[POS_STAGE] = fault.stage2;
		fault_word[POS_LEVEL +: 2] = fault.level;
		fault_word[POS_OP_TERM] = fault.op_terminated;
		fault_word[POS_INV_CTX] = fault.invalid_context;
		fault_word[POS_SCHEME +: 2] = scheme;
		fault_word[POS_ADDR_SIZE] = fault.addr_size;
		fault_word[POS_LOCK] = HAS_LOCK && fault.cache_lock;
		fault_word[POS_MATCH] = HAS_MATCH && fault.match_conflict;
		fault_word[POS_EXT] = HAS_EXT && fault.external;
		fault_word[POS_PERM] = fault.permission;
		fault_word[POS_ACCESS] = fault.access_bit;
		fault_word[POS_NO_MAP] = fault.no_mapping;
	end

	always_comb begin
		cfg_word = '0;
		if (group.revealed) begin
			cfg_word[4:0] = group.counter_count;
			cfg_word[POS_CFG_SIZE +: 6] = CFG_SIZE_REVEALED;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.slverr = 1'b0;
		s_d.clr = '0;
		s_d.set = '0;
		if (acc && !apb_req.pwrite) begin
			s_d.rdata = '0;
			unique case (apb_req.paddr)
				OFF_RESULT_LO: s_d.rdata = s_q.result[31:0];
				OFF_RESULT_HI: s_d.rdata = s_q.result[63:32];
				OFF_AUTH: s_d.rdata = group.revealed ? group.auth : '0;
				OFF_CEID_LO: s_d.rdata = group.revealed ? group.ceid_lo : '0;
				OFF_CEID_HI: s_d.rdata = group.revealed ? group.ceid_hi : '0;
				OFF_MON_CFG: s_d.rdata = cfg_word;
				OFF_CNT_CLR, OFF_CNT_SET: begin
					s_d.rdata = group.revealed ? (group.enables & cnt_mask) : '0;
				end
				OFF_CTX_CFG: begin
					s_d.rdata[POS_CTX_WIDE] = s_q.wide;
					s_d.rdata[POS_CTX_EXT] = s_q.ext;
					s_d.rdata[POS_CTX_STAGE2] = s_q.stage2;
				end
				default: s_d.slverr = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (apb_req.paddr)
				OFF_RESULT_LO: begin
					// Scheme bits are never stored from software
					s_d.result[POS_FAULT] = apb_req.pwdata[POS_FAULT];
					s_d.result[POS_ADDR_SIZE:POS_NO_MAP] =
						apb_req.pwdata[POS_ADDR_SIZE:POS_NO_MAP];
					if (!HAS_LOCK) s_d.result[POS_LOCK] = 1'b0;
					if (!HAS_MATCH) s_d.result[POS_MATCH] = 1'b0;
					if (!HAS_EXT) s_d.result[POS_EXT] = 1'b0;
					s_d.result[POS_INV_CTX] = apb_req.pwdata[POS_INV_CTX];
					s_d.result[POS_OP_TERM] = apb_req.pwdata[POS_OP_TERM];
				end
				OFF_RESULT_HI: begin
					s_d.result[POS_LEVEL +: 2] = apb_req.pwdata[1:0];
					s_d.result[POS_STAGE] = apb_req.pwdata[3];
				end
				OFF_CNT_CLR: begin
					if (group.revealed) s_d.clr = apb_req.pwdata & cnt_mask;
				end
				OFF_CNT_SET: begin
					if (group.revealed) s_d.set = apb_req.pwdata & cnt_mask;
				end
				OFF_CTX_CFG: begin
					// Software keeps this stable with faults pending
					s_d.wide = apb_req.pwdata[POS_CTX_WIDE];
					s_d.ext = apb_req.pwdata[POS_CTX_EXT];
					s_d.stage2 = apb_req.pwdata[POS_CTX_STAGE2];
				end
				OFF_AUTH, OFF_CEID_LO, OFF_CEID_HI, OFF_MON_CFG: ;
				default: s_d.slverr = 1'b1;
			endcase
		end
		// Hardware abort wins over a same-cycle software write
		if (fault.valid) begin
			s_d.result = fault_word;
		end
		// Scheme field always tracks configuration
		s_d.result[POS_SCHEME +: 2] = scheme_of(s_d.wide, s_d.ext, s_d.stage2);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.result <= RESULT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = acc && s_d.slverr;
	assign apb_rsp.prdata = s_d.rdata;
	assign enable_clear = s_q.clr;
	assign enable_set = s_q.set;
	assign wide_scheme_select = s_q.wide;
	assign extended_addr_enable = s_q.ext;

	a_abort_sets_fault: assert property (@(posedge clk) disable iff (!rst_n)
		fault.valid |=> s_q.result[0])
		else $error("fault bit not set after abort");
	a_stage_level_cap: assert property (@(posedge clk) disable iff (!rst_n)
		fault.valid |=> s_q.result[35:32] ==
		{$past(fault.stage2), 1'b0, $past(fault.level)})
		else $error("stage or level wrong");
	a_term_flag: assert property (@(posedge clk) disable iff (!rst_n)
		fault.valid |=> s_q.result[31] == $past(fault.op_terminated))
		else $error("terminated flag wrong");
	a_scheme_no_short: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.stage2 |-> s_q.result[9:8] != SCHEME_SHORT)
		else $error("short scheme on stage 2");
	a_scheme_wide: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.wide |-> s_q.result[9:8] == SCHEME_WIDE)
		else $error("wide scheme code wrong");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.result[63:36] == '0 && !s_q.result[34] && !s_q.result[30]
		&& s_q.result[28:10] == '0)
		else $error("reserved bits nonzero");
	a_cfg_unrevealed: assert property (@(posedge clk) disable iff (!rst_n)
		!group.revealed |-> cfg_word == '0)
		else $error("config not zero when hidden");
	a_clear_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.clr != '0 |-> $past(wr) && $past(group.revealed))
		else $error("clear pulse without write");
	a_set_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.set != '0 |-> $past(wr) && $past(group.revealed))
		else $error("set pulse without write");

	// Steps of the checked behaviours
	sequence s_abort;
		fault.valid;
	endsequence

	sequence s_read(logic [11:0] a);
		acc && !apb_req.pwrite && apb_req.paddr == a;
	endsequence

	sequence s_write(logic [11:0] a);
		wr && apb_req.paddr == a;
	endsequence

	sequence s_quiet;
		!fault.valid && !wr;
	endsequence

	// Fault layout fields after an abort
	a_stage_bit: assert property (
		s_abort |=> s_q.result[POS_STAGE] == $past(fault.stage2))
		else $error("stage bit wrong");

	a_level_field: assert property (
		s_abort |=> s_q.result[POS_LEVEL +: 2] == $past(fault.level))
		else $error("walk level wrong");

	a_inv_ctx_flag: assert property (
		s_abort |=>
		s_q.result[POS_INV_CTX] == $past(fault.invalid_context))
		else $error("invalid context flag wrong");

	a_addr_size_flag: assert property (
		s_abort |=> s_q.result[POS_ADDR_SIZE] == $past(fault.addr_size))
		else $error("address size flag wrong");

	a_lock_flag: assert property (
		s_abort |=>
		s_q.result[POS_LOCK] == (HAS_LOCK && $past(fault.cache_lock)))
		else $error("cache lock flag wrong");

	a_match_flag: assert property (
		s_abort |=>
		s_q.result[POS_MATCH] == (HAS_MATCH && $past(fault.match_conflict)))
		else $error("match conflict flag wrong");

	a_ext_flag: assert property (
		s_abort |=>
		s_q.result[POS_EXT] == (HAS_EXT && $past(fault.external)))
		else $error("external flag wrong");

	a_perm_flag: assert property (
		s_abort |=> s_q.result[POS_PERM] == $past(fault.permission))
		else $error("permission flag wrong");

	a_access_flag: assert property (
		s_abort |=> s_q.result[POS_ACCESS] == $past(fault.access_bit))
		else $error("access flag wrong");

	a_no_map_flag: assert property (
		s_abort |=> s_q.result[POS_NO_MAP] == $past(fault.no_mapping))
		else $error("no mapping flag wrong");

	a_result_quiet: assert property (
		s_quiet |=> $stable(s_q.result))
		else $error("result changed without cause");

	// Scheme field against the context configuration
	a_scheme_short: assert property (
		!s_q.wide && !s_q.ext && !s_q.stage2 |->
		s_q.result[POS_SCHEME +: 2] == SCHEME_SHORT)
		else $error("short scheme code wrong");

	a_scheme_long: assert property (
		!s_q.wide && (s_q.ext || s_q.stage2) |->
		s_q.result[POS_SCHEME +: 2] == SCHEME_LONG)
		else $error("long scheme code wrong");

	a_scheme_no_rsv: assert property (
		s_q.result[POS_SCHEME +: 2] != 2'h3)
		else $error("reserved scheme code reported");

	a_scheme_tracks: assert property (
		s_q.result[POS_SCHEME +: 2] == scheme)
		else $error("scheme field not from config");

	// Register reads
	a_result_lo_read: assert property (
		s_read(OFF_RESULT_LO) |-> apb_rsp.prdata == s_q.result[31:0])
		else $error("result low read wrong");

	a_result_hi_read: assert property (
		s_read(OFF_RESULT_HI) |-> apb_rsp.prdata == s_q.result[63:32])
		else $error("result high read wrong");

	a_auth_mirror: assert property (
		s_read(OFF_AUTH) |->
		apb_rsp.prdata == (group.revealed ? group.auth : 32'h0))
		else $error("auth mirror read wrong");

	a_ceid_low: assert property (
		s_read(OFF_CEID_LO) |->
		apb_rsp.prdata == (group.revealed ? group.ceid_lo : 32'h0))
		else $error("event id low read wrong");

	a_ceid_high: assert property (
		s_read(OFF_CEID_HI) |->
		apb_rsp.prdata == (group.revealed ? group.ceid_hi : 32'h0))
		else $error("event id high read wrong");

	a_cfg_read: assert property (
		s_read(OFF_MON_CFG) |-> apb_rsp.prdata == cfg_word)
		else $error("monitor config read wrong");

	a_cfg_count: assert property (
		group.revealed |-> cfg_word[4:0] == group.counter_count)
		else $error("counter count field wrong");

	a_cfg_size: assert property (
		group.revealed |->
		cfg_word[POS_CFG_SIZE +: 6] == CFG_SIZE_REVEALED)
		else $error("size field wrong when revealed");

	a_enables_read: assert property (
		(s_read(OFF_CNT_CLR) or s_read(OFF_CNT_SET)) |->
		apb_rsp.prdata ==
		(group.revealed ? (group.enables & cnt_mask) : 32'h0))
		else $error("enable read wrong");

	// Enable clear and set pulses
	a_clear_value: assert property (
		s_write(OFF_CNT_CLR) ##0 group.revealed |=>
		enable_clear == ($past(apb_req.pwdata) & cnt_mask))
		else $error("clear pulse value wrong");

	a_set_value: assert property (
		s_write(OFF_CNT_SET) ##0 group.revealed |=>
		enable_set == ($past(apb_req.pwdata) & cnt_mask))
		else $error("set pulse value wrong");

	a_clear_hidden: assert property (
		s_write(OFF_CNT_CLR) ##0 !group.revealed |=> enable_clear == '0)
		else $error("clear pulse while hidden");

	a_set_hidden: assert property (
		s_write(OFF_CNT_SET) ##0 !group.revealed |=> enable_set == '0)
		else $error("set pulse while hidden");

	a_clear_masked: assert property (
		(enable_clear & ~cnt_mask) == '0)
		else $error("clear pulse beyond counters");

	a_set_masked: assert property (
		(enable_set & ~cnt_mask) == '0)
		else $error("set pulse beyond counters");
endmodule

// ### dv/cfrr_regs_tb_top.sv
// Self-checking bench for the context fault result register slice
`timescale 1ns/10ps
module cfrr_regs_tb_top;
	import cfrr_pkg::*;
	typedef struct {
		logic [2:0] cfg;
		logic [12:0] f;
		logic [31:0] lo;
		logic [31:0] hi;
	} cfrr_row_t;
	logic clk;
	logic rst_n;
	cfrr_apb_req_t apb_req;
	cfrr_apb_rsp_t apb_rsp;
	cfrr_fault_t fault;
	cfrr_group_t group;
	logic [31:0] enable_clear;
	logic [31:0] enable_set;
	logic wide_scheme_select;
	logic extended_addr_enable;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	cfrr_row_t rows [5];

	cfrr_regs dut (
		.clk(clk),
		.rst_n(rst_n),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.fault(fault),
		.group(group),
		.enable_clear(enable_clear),
		.enable_set(enable_set),
		.wide_scheme_select(wide_scheme_select),
		.extended_addr_enable(extended_addr_enable)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task complete_run;
		$display("Mismatches %0d, checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run;
		end
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		// Idle edge keeps back-to-back calls from reassigning psel
		@(posedge clk);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	initial begin
		apb_req = '0;
		fault = '0;
		group = '0;
		rst_n = 1'b0;
		rows[0] = '{3'h0, 13'h1001, 32'h00000003, 32'h00000000};
		rows[1] = '{3'h2, 13'h1202, 32'h00000105, 32'h00000001};
		rows[2] = '{3'h1, 13'h140C, 32'h00000219, 32'h00000002};
		rows[3] = '{3'h3, 13'h1FF0, 32'hA00002E1, 32'h0000000B};
		rows[4] = '{3'h4, 13'h1801, 32'h00000103, 32'h00000008};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(OFF_RESULT_LO, RESULT_RESET[31:0]);
		rchk(OFF_RESULT_HI, RESULT_RESET[63:32]);
		rchk(OFF_MON_CFG, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, OFF_CTX_CFG, {29'h0, rows[i].cfg});
			fault <= rows[i].f;
			@(posedge clk);
			fault <= '0;
			@(posedge clk);
			chk({wide_scheme_select, extended_addr_enable},
				{rows[i].cfg[0], rows[i].cfg[1]});
			rchk(OFF_RESULT_LO, rows[i].lo);
			rchk(OFF_RESULT_HI, rows[i].hi);
		end
		// Reserved and scheme bits ignore writes
		apb(1'b1, OFF_CTX_CFG, 32'h0);
		apb(1'b1, OFF_RESULT_LO, 32'hFFFFFFFF);
		apb(1'b1, OFF_RESULT_HI, 32'hFFFFFFFF);
		rchk(OFF_RESULT_LO, 32'hA00000FF);
		rchk(OFF_RESULT_HI, 32'h0000000B);
		// No group revealed
		apb(1'b1, OFF_CNT_CLR, 32'hFFFFFFFF);
		@(posedge clk);
		chk(enable_clear, 32'h0);
		rchk(OFF_AUTH, 32'h0);
		rchk(OFF_CEID_LO, 32'h0);
		rchk(OFF_CEID_HI, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk(err, 1'b1);
		// Group revealed
		group <= '{1'b1, 32'h000000AA, 32'h12345678, 32'h9ABCDEF0,
			32'h0000F00F, 5'h07};
		@(posedge clk);
		rchk(OFF_AUTH, 32'h000000AA);
		rchk(OFF_CEID_LO, 32'h12345678);
		rchk(OFF_CEID_HI, 32'h9ABCDEF0);
		apb(1'b1, OFF_MON_CFG, 32'hFFFFFFFF);
		rchk(OFF_MON_CFG, 32'h00001F07);
		rchk(OFF_CNT_CLR, 32'h0000F00F);
		apb(1'b1, OFF_CNT_CLR, 32'h00000005);
		chk(enable_clear, 32'h00000005);
		@(posedge clk);
		chk(enable_clear, 32'h0);
		apb(1'b1, OFF_CNT_SET, 32'h0000000A);
		chk(enable_set, 32'h0000000A);
		@(posedge clk);
		chk(enable_set, 32'h0);
		// Mid-run reset returns every register to zero
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({wide_scheme_select, extended_addr_enable}, 2'h0);
		rchk(OFF_RESULT_LO, 32'h0);
		// Abort wins over a same-edge write of the low word
		apb_req.psel <= 1'b1;
		apb_req.pwrite <= 1'b1;
		apb_req.paddr <= OFF_RESULT_LO;
		apb_req.pwdata <= 32'h0;
		@(posedge clk);
		apb_req.penable <= 1'b1;
		fault <= 13'h1001;
		@(posedge clk);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		fault <= '0;
		@(posedge clk);
		rchk(OFF_RESULT_LO, 32'h00000003);
		complete_run;
	end
endmodule
